/* src/wdms_params.svh */
// Constants of the watchdog mode sequencer: register offsets, field positions,
// reset values and divider counts. Included by the package and the design.
`ifndef WDMS_PARAMS_SVH
`define WDMS_PARAMS_SVH

`define WDMS_ADDR_W          8
`define WDMS_OFS_MAIN        8'h00
`define WDMS_OFS_SECONDARY   8'h04
`define WDMS_OFS_STATUS      8'h08
`define WDMS_OFS_NMI         8'h0C
`define WDMS_OFS_RESET       8'h10

// Main control access kinds, written to bits [1:0] of the main control word
`define WDMS_ACC_PASSWORD    2'h1
`define WDMS_ACC_MODIFY      2'h2
`define WDMS_MAIN_KIND_LSB   0
`define WDMS_MAIN_INIT_BIT   2
`define WDMS_MAIN_VALID_BIT  3
`define WDMS_MAIN_RELOAD_LSB 16

`define WDMS_SEC_RATE_BIT    0
`define WDMS_SEC_DISREQ_BIT  1

`define WDMS_START_VALUE     16'hFFFC
`define WDMS_MID_VALUE       16'h7FFF
`define WDMS_ALL_ONES        16'hFFFF
`define WDMS_RELOAD_RST      16'h0000
`define WDMS_DIV_FAST        256
`define WDMS_DIV_SLOW        16384

`define WDMS_RESP_OKAY       2'h0
`define WDMS_RESP_SLVERR     2'h2

`endif

/* src/wdms_pkg.sv */
// Types of the watchdog mode sequencer.
// Assumes wdms_params.svh is on the include path.
`include "wdms_params.svh"
package wdms_pkg;
  typedef enum logic [1:0] {
    WDMS_TIMEOUT,
    WDMS_NORMAL,
    WDMS_DISABLE,
    WDMS_PREWARN
  } wdms_mode_t;

  typedef struct packed {
    logic        access_error_flag;
    logic        overflow_error_flag;
    logic        prewarning_flag;
    logic        timeout_indication_flag;
    logic        disabled_status_flag;
    logic        input_select_status;
  } wdms_status_t;
endpackage

/* src/wdms_top.sv */
// Watchdog mode sequencer: 16-bit up counter, four modes, AXI4-Lite registers.
// Assumes one clock core_clk and synchronous srst; the password and guard
// checks are done upstream and arrive as one valid bit in the write data.
// How it works
// - Timeout to normal on init_end with no disable
// - Normal entry loads counter with reload value
// - Normal entry clears error, prewarn, timeout, disabled
// - Normal counts up at selected prescaled rate
// - Valid password in normal returns to timeout
// - Normal overflow sets overflow error, prewarns
// - Normal invalid access sets access error, prewarns
// - Timeout to disable on init_end with request
// - Disable holds counter value
// - Disable: password to timeout, invalid to prewarn
// - Prewarn entry sets NMI watchdog flag
// - Prewarn entry loads start, sets prewarn flag
// - Prewarn entry keeps timeout indication flag
// - Prewarn never changes mode; invalid sets error
// - Prewarn refuses secondary writes with bus error
// - Prewarn overflow resets system, sets reset flag
// - Top bit rising raises NMI while counting
// - Mid-count NMI leaves mode unchanged
// - Soft reset clears errors, watchdog reset keeps
// - Timeout entry loads start, sets timeout flag
// - Valid modify sets the lock bit again
// - Divider gives clock by 256 or 16384
// - Rate request copied when init_end set
//
// Chosen here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "wdms_params.svh"
module wdms_top
  import wdms_pkg::*;
#(
  parameter int DIV_FAST = `WDMS_DIV_FAST,
  parameter int DIV_SLOW = `WDMS_DIV_SLOW
) (
  input  wire logic        core_clk,          // System clock, 100 MHz
  input  wire logic        srst,              // Synchronous reset, active high
  input  wire logic        wd_reset_cause,    // 1: last reset came from this watchdog
  input  wire logic [7:0]  s_axi_awaddr,      // Write address
  input  wire logic        s_axi_awvalid,     // Write address valid
  output logic             s_axi_awready,     // Write address ready
  input  wire logic [31:0] s_axi_wdata,       // Write data
  input  wire logic [3:0]  s_axi_wstrb,       // Write strobes
  input  wire logic        s_axi_wvalid,      // Write data valid
  output logic             s_axi_wready,      // Write data ready
  output logic [1:0]       s_axi_bresp,       // Write response
  output logic             s_axi_bvalid,      // Write response valid
  input  wire logic        s_axi_bready,      // Write response ready
  input  wire logic [7:0]  s_axi_araddr,      // Read address
  input  wire logic        s_axi_arvalid,     // Read address valid
  output logic             s_axi_arready,     // Read address ready
  output logic [31:0]      s_axi_rdata,       // Read data
  output logic [1:0]       s_axi_rresp,       // Read response
  output logic             s_axi_rvalid,      // Read data valid
  input  wire logic        s_axi_rready,      // Read data ready
  output logic             nmi_req,           // One-cycle NMI request pulse
  output logic             sys_reset_req      // One-cycle system reset request
);

  // Divider counts must stay ordered and fit the 16-bit prescaler
  if (DIV_FAST < 2 || DIV_SLOW <= DIV_FAST) begin : g_bad_div_order
    $error("wdms_top: divider values unusable");
  end
  if (DIV_SLOW > 65536) begin : g_bad_div_width
    $error("wdms_top: slow divider exceeds prescaler width");
  end

  wdms_mode_t   mode_q;
  wdms_status_t st_q;
  logic [15:0]  wd_counter_q;
  logic [15:0]  reload_value_q;
  logic         init_end_bit_q;
  logic         lock_bit_q;
  logic         input_rate_request_q;
  logic         disable_request_bit_q;
  logic         nmi_watchdog_flag_q;
  logic         watchdog_reset_flag_q;
  logic [15:0]  div_q;
  logic         aw_held_q;
  logic         w_held_q;
  logic [7:0]   aw_addr_q;
  logic [31:0]  w_data_q;
  logic [3:0]   w_strb_q;

  // Write channel: address and data latched independently, then one write cycle
  wire         wr_go    = aw_held_q && w_held_q && !s_axi_bvalid;
  wire         wr_main  = wr_go && aw_addr_q == `WDMS_OFS_MAIN && w_strb_q[0];
  wire         wr_sec   = wr_go && aw_addr_q == `WDMS_OFS_SECONDARY;
  wire         wr_nmi   = wr_go && aw_addr_q == `WDMS_OFS_NMI && w_strb_q[0];
  wire         wr_rst   = wr_go && aw_addr_q == `WDMS_OFS_RESET && w_strb_q[0];
  wire         wr_known = wr_main || wr_sec || wr_nmi || wr_rst ||
                          (wr_go && aw_addr_q == `WDMS_OFS_STATUS);
  wire [1:0]   acc_kind = w_data_q[`WDMS_MAIN_KIND_LSB +: 2];
  wire         acc_ok   = w_data_q[`WDMS_MAIN_VALID_BIT];
  wire         pw_valid = wr_main && acc_kind == `WDMS_ACC_PASSWORD && acc_ok;
  wire         md_valid = wr_main && acc_kind == `WDMS_ACC_MODIFY && acc_ok && !lock_bit_q;
  wire         acc_bad  = wr_main && !pw_valid && !md_valid;
  wire         md_init  = md_valid && w_data_q[`WDMS_MAIN_INIT_BIT];
  wire         sec_deny = mode_q == WDMS_PREWARN || init_end_bit_q;

  // Prescaler runs free, not synchronised to mode changes
  wire [15:0]  div_last = st_q.input_select_status ? 16'(DIV_FAST - 1) : 16'(DIV_SLOW - 1);
  wire         tick     = div_q >= div_last;
  wire         counting = mode_q != WDMS_DISABLE;
  wire         cnt_inc  = tick && counting;
  wire         ovf      = cnt_inc && wd_counter_q == `WDMS_ALL_ONES;
  wire         mid      = cnt_inc && wd_counter_q == `WDMS_MID_VALUE;
  wire         to_prew  = mode_q != WDMS_PREWARN && (ovf || acc_bad);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      div_q <= 16'h0000;
    end else if (tick) begin
      div_q <= 16'h0000;
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      mode_q <= WDMS_TIMEOUT;
    end else begin
      case (mode_q)
        WDMS_TIMEOUT: begin
          if (to_prew) begin
            mode_q <= WDMS_PREWARN;
          end else if (md_init) begin
            mode_q <= disable_request_bit_q ? WDMS_DISABLE : WDMS_NORMAL;
          end
        end
        WDMS_NORMAL, WDMS_DISABLE: begin
          if (to_prew) begin
            mode_q <= WDMS_PREWARN;
          end else if (pw_valid) begin
            mode_q <= WDMS_TIMEOUT;
          end
        end
        WDMS_PREWARN: begin
          mode_q <= WDMS_PREWARN;
        end
        default: begin
          mode_q <= WDMS_TIMEOUT;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      wd_counter_q <= `WDMS_START_VALUE;
    end else if (to_prew) begin
      wd_counter_q <= `WDMS_START_VALUE;
    end else if (pw_valid && (mode_q == WDMS_NORMAL || mode_q == WDMS_DISABLE)) begin
      wd_counter_q <= `WDMS_START_VALUE;
    end else if (md_init && mode_q == WDMS_TIMEOUT && !disable_request_bit_q) begin
      wd_counter_q <= w_data_q[`WDMS_MAIN_RELOAD_LSB +: 16];
    end else if (cnt_inc) begin
      wd_counter_q <= wd_counter_q + 16'h0001;
    end
  end

  // Status flags; a soft reset clears errors, a watchdog reset keeps them
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_q.access_error_flag       <= wd_reset_cause & st_q.access_error_flag;
      st_q.overflow_error_flag     <= wd_reset_cause & st_q.overflow_error_flag;
      st_q.prewarning_flag         <= 1'b0;
      st_q.timeout_indication_flag <= 1'b1;
      st_q.disabled_status_flag    <= 1'b0;
      st_q.input_select_status     <= 1'b0;
    end else begin
      if (acc_bad) begin
        st_q.access_error_flag <= 1'b1;
      end else if (md_init && mode_q == WDMS_TIMEOUT) begin
        st_q.access_error_flag <= 1'b0;
      end
      if (ovf && mode_q != WDMS_PREWARN) begin
        st_q.overflow_error_flag <= 1'b1;
      end else if (md_init && mode_q == WDMS_TIMEOUT) begin
        st_q.overflow_error_flag <= 1'b0;
      end
      if (to_prew) begin
        st_q.prewarning_flag      <= 1'b1;
        st_q.disabled_status_flag <= 1'b0;
      end else if (pw_valid && (mode_q == WDMS_NORMAL || mode_q == WDMS_DISABLE)) begin
        st_q.timeout_indication_flag <= 1'b1;
        st_q.disabled_status_flag    <= 1'b0;
      end else if (md_init && mode_q == WDMS_TIMEOUT) begin
        st_q.prewarning_flag         <= 1'b0;
        st_q.timeout_indication_flag <= 1'b0;
        st_q.disabled_status_flag    <= disable_request_bit_q;
      end
      if (md_init) begin
        st_q.input_select_status <= input_rate_request_q;
      end
    end
  end

  // A password opens the main control word for exactly one modify access;
  // a failed access closes it again so a stray write cannot reuse the opening
  always_ff @(posedge core_clk) begin
    if (srst) begin
      lock_bit_q <= 1'b1;
    end else if (pw_valid) begin
      lock_bit_q <= 1'b0;
    end else if (md_valid) begin
      lock_bit_q <= 1'b1;
    end else if (acc_bad) begin
      lock_bit_q <= 1'b1;
    end
  end

  // Reset opens the protected registers; only a valid modify changes this
  always_ff @(posedge core_clk) begin
    if (srst) begin
      init_end_bit_q <= 1'b0;
    end else if (md_valid) begin
      init_end_bit_q <= w_data_q[`WDMS_MAIN_INIT_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      reload_value_q <= `WDMS_RELOAD_RST;
    end else if (md_valid) begin
      reload_value_q <= w_data_q[`WDMS_MAIN_RELOAD_LSB +: 16];
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      input_rate_request_q  <= 1'b0;
      disable_request_bit_q <= 1'b0;
    end else if (wr_sec && !sec_deny && w_strb_q[0]) begin
      input_rate_request_q  <= w_data_q[`WDMS_SEC_RATE_BIT];
      disable_request_bit_q <= w_data_q[`WDMS_SEC_DISREQ_BIT];
    end
  end

  // NMI flag: hardware set wins over a software clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (srst) begin
      nmi_watchdog_flag_q <= 1'b0;
    end else begin
      if (to_prew || mid) begin
        nmi_watchdog_flag_q <= 1'b1;
      end else if (wr_nmi && w_data_q[0]) begin
        nmi_watchdog_flag_q <= 1'b0;
      end
    end
  end

  // Request is a pulse; the level lives in the NMI flag until software clears it
  always_ff @(posedge core_clk) begin
    if (srst) begin
      nmi_req <= 1'b0;
    end else begin
      nmi_req <= to_prew || mid;
    end
  end

  // Watchdog reset flag survives an srst with wd_reset_cause set so software can see the cause; any other srst clears it
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sys_reset_req <= 1'b0;
    end else begin
      sys_reset_req <= ovf && mode_q == WDMS_PREWARN;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_reset_req) begin
      watchdog_reset_flag_q <= 1'b1;
    end else if (srst) begin
      watchdog_reset_flag_q <= watchdog_reset_flag_q & wd_reset_cause;
    end else if (wr_rst && w_data_q[0]) begin
      watchdog_reset_flag_q <= 1'b0;
    end
  end

  // AXI4-Lite write side; ready pulses so each channel takes one beat only
  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_q && !s_axi_awready;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_held_q && !s_axi_wready;
    end
  end

  // Held beats stay until the response is taken, which blocks a second write
  always_ff @(posedge core_clk) begin
    if (srst) begin
      aw_held_q     <= 1'b0;
      w_held_q      <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `WDMS_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (!wr_known || (wr_sec && sec_deny)) ? `WDMS_RESP_SLVERR : `WDMS_RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_held_q    <= 1'b0;
        w_held_q     <= 1'b0;
      end
    end
  end

  // AXI4-Lite read side; no new address while read data waits
  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_axi_arready <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `WDMS_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= `WDMS_RESP_OKAY;
        case (s_axi_araddr)
          `WDMS_OFS_MAIN:      s_axi_rdata <= {reload_value_q, 12'h000, init_end_bit_q, lock_bit_q, 2'h0};
          `WDMS_OFS_SECONDARY: s_axi_rdata <= {30'h0, disable_request_bit_q, input_rate_request_q};
          `WDMS_OFS_STATUS:    s_axi_rdata <= {wd_counter_q, 8'h00, mode_q, st_q};
          `WDMS_OFS_NMI:       s_axi_rdata <= {31'h0, nmi_watchdog_flag_q};
          `WDMS_OFS_RESET:     s_axi_rdata <= {31'h0, watchdog_reset_flag_q};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `WDMS_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

/* test/tb_top.sv */
// Bench of wdms_top: register walk from a row table, then mode scenarios.
// Assumes short divider counts so each timeout lasts a few hundred cycles.
`timescale 1ns/1ps
`include "wdms_params.svh"
module tb_top;
  localparam int DF = 16; // Short dividers keep the run brief
  localparam int DS = 64;
  typedef struct {
    logic        wr;
    logic [7:0]  a;
    logic [31:0] d;
    logic        bad;
    logic [31:0] m;
    logic [31:0] e;
  } wdms_row_t;
  logic        core_clk = 1'b0;
  logic        srst = 1'b1;
  logic        wd_reset_cause = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, last_rd, held;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        nmi_req, sys_reset_req;
  int          err_total = 0, n_tests = 0, nmi_cnt = 0, rst_cnt = 0, base;
  wdms_row_t   rows [18] = '{
    '{1'b0, 8'h08, 32'h0, 1'b0, 32'hFF, 32'h04},
    '{1'b0, 8'h00, 32'h0, 1'b0, 32'hFFFFFFFF, 32'h04},
    '{1'b0, 8'h14, 32'h0, 1'b1, 32'h0, 32'h0},
    '{1'b1, 8'h14, 32'h0, 1'b1, 32'h0, 32'h0},
    '{1'b1, 8'h04, 32'h1, 1'b0, 32'h0, 32'h0},
    '{1'b0, 8'h08, 32'h0, 1'b0, 32'hFF, 32'h04},
    '{1'b1, 8'h00, 32'h9, 1'b0, 32'h0, 32'h0},
    '{1'b1, 8'h00, 32'hFFE0000E, 1'b0, 32'h0, 32'h0},
    '{1'b0, 8'h08, 32'h0, 1'b0, 32'hFFFE00FF, 32'hFFE00041},
    '{1'b0, 8'h00, 32'h0, 1'b0, 32'hFFFFFFFF, 32'hFFE0000C},
    '{1'b1, 8'h04, 32'h3, 1'b1, 32'h0, 32'h0},
    '{1'b1, 8'h00, 32'h9, 1'b0, 32'h0, 32'h0},
    '{1'b0, 8'h08, 32'h0, 1'b0, 32'hFFFE00FF, 32'hFFFC0005},
    '{1'b1, 8'h00, 32'hA, 1'b0, 32'h0, 32'h0},
    '{1'b1, 8'h04, 32'h3, 1'b0, 32'h0, 32'h0},
    '{1'b1, 8'h00, 32'h9, 1'b0, 32'h0, 32'h0},
    '{1'b1, 8'h00, 32'hE, 1'b0, 32'h0, 32'h0},
    '{1'b0, 8'h08, 32'h0, 1'b0, 32'hFF, 32'h83}
  };

  wdms_top #(.DIV_FAST(DF), .DIV_SLOW(DS)) i_wdms_top (
    .core_clk, .srst, .wd_reset_cause, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .nmi_req, .sys_reset_req
  );

  always #5 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    if (nmi_req === 1'b1) nmi_cnt <= nmi_cnt + 1;
    if (sys_reset_req === 1'b1) rst_cnt <= rst_cnt + 1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rst(input logic cause);
    wd_reset_cause <= cause;
    srst <= 1'b1;
    repeat (8) @(posedge core_clk);
    srst <= 1'b0;
    wd_reset_cause <= 1'b0;
  endtask

  // Both write channels offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic bad);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, bad ? {30'h0, `WDMS_RESP_SLVERR} : 32'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic bad);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    last_rd = s_axi_rdata;
    chk({30'h0, s_axi_rresp}, bad ? {30'h0, `WDMS_RESP_SLVERR} : 32'h0);
    chk(s_axi_rdata & m, e);
  endtask

  // Waits for a pulse counted after base; sel picks system reset over NMI
  task automatic wait_ev(input logic sel, input int b, input int lim);
    int n = 0;
    while ((sel ? rst_cnt : nmi_cnt) <= b && n < lim) begin
      @(posedge core_clk);
      n++;
    end
    chk({31'h0, (sel ? rst_cnt : nmi_cnt) > b}, 32'h1);
  endtask

  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    #400000;
    err_total++;
    test_done;
  end

  initial begin
    rst(1'b0);
    foreach (rows[i]) begin
      if (rows[i].wr) wr(rows[i].a, rows[i].d, rows[i].bad);
      else rd(rows[i].a, rows[i].m, rows[i].e, rows[i].bad);
    end
    rd(8'h08, 32'h0, 32'h0, 1'b0);
    held = last_rd & 32'hFFFF0000;
    repeat (100) @(posedge core_clk);
    rd(8'h08, 32'hFFFF0000, held, 1'b0);
    base = nmi_cnt;
    wr(8'h00, 32'h1, 1'b0);
    wait_ev(1'b0, base, 20);
    rd(8'h08, 32'hFF, 32'hE9, 1'b0);
    rd(8'h0C, 32'h1, 32'h1, 1'b0);
    wr(8'h04, 32'h0, 1'b1);
    wr(8'h00, 32'h9, 1'b0);
    rd(8'h08, 32'hC0, 32'hC0, 1'b0);
    wait_ev(1'b1, 0, 200);
    rd(8'h10, 32'h1, 32'h1, 1'b0);
    rst(1'b1);
    rd(8'h08, 32'hFF, 32'h24, 1'b0);
    rd(8'h10, 32'h1, 32'h1, 1'b0);
    rst(1'b0);
    rd(8'h08, 32'hFF, 32'h04, 1'b0);
    rd(8'h10, 32'h1, 32'h0, 1'b0);
    wr(8'h04, 32'h1, 1'b0);
    wr(8'h00, 32'h9, 1'b0);
    wr(8'h00, 32'h7FF0000E, 1'b0);
    rd(8'h08, 32'hFFFE00FF, 32'h7FF00041, 1'b0);
    base = nmi_cnt;
    wait_ev(1'b0, base, 400);
    rd(8'h08, 32'hFF, 32'h41, 1'b0);
    base = nmi_cnt;
    wr(8'h00, 32'h1, 1'b0);
    wait_ev(1'b0, base, 20);
    rd(8'h08, 32'hFF, 32'hE9, 1'b0);
    rst(1'b0);
    wr(8'h04, 32'h1, 1'b0);
    wr(8'h00, 32'h9, 1'b0);
    base = nmi_cnt;
    wr(8'h00, 32'hFFF0000E, 1'b0);
    wait_ev(1'b0, base, 400);
    rd(8'h08, 32'hFF, 32'hD9, 1'b0);
    rst(1'b0);
    base = nmi_cnt;
    wait_ev(1'b0, base, 400);
    rd(8'h08, 32'hFF, 32'hDC, 1'b0);
    test_done;
  end
endmodule

bind wdms_top wdms_chk i_wdms_chk (
  .core_clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .nmi_req, .sys_reset_req
);

/* test/wdms_chk.sv */
// Checker of wdms_top ports: bus timing, pulse widths, refusals.
// Assumes one clock and the synchronous active-high srst.
`timescale 1ns/1ps
`include "wdms_params.svh"
module wdms_chk (
  input wire logic       core_clk,      // Clock
  input wire logic       srst,          // Reset
  input wire logic [7:0] s_axi_awaddr,  // AW addr
  input wire logic       s_axi_awvalid, // AW valid
  input wire logic       s_axi_awready, // AW ready
  input wire logic       s_axi_wvalid,  // W valid
  input wire logic       s_axi_wready,  // W ready
  input wire logic [1:0] s_axi_bresp,   // B resp
  input wire logic       s_axi_bvalid,  // B valid
  input wire logic       s_axi_arvalid, // AR valid
  input wire logic       s_axi_arready, // AR ready
  input wire logic       s_axi_rvalid,  // R valid
  input wire logic       nmi_req,       // NMI pulse
  input wire logic       sys_reset_req  // Reset pulse
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  logic wr_hs;
  assign wr_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;

  a_quiet_reset: assert property (disable iff (1'b0) srst |=> !nmi_req && !sys_reset_req)
    else $error("Request pulse right after reset");
  a_nmi_single: assert property (nmi_req |=> !nmi_req)
    else $error("NMI request longer than one cycle");
  a_rst_single: assert property (sys_reset_req |=> !sys_reset_req)
    else $error("System reset request longer than one cycle");
  a_rst_no_nmi: assert property (sys_reset_req |-> !nmi_req)
    else $error("NMI request together with system reset");
  a_b_latency: assert property (wr_hs |-> ##2 s_axi_bvalid)
    else $error("Write response not two cycles after handshake");
  a_r_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("Read data not one cycle after handshake");
  a_one_write: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("Write taken while a response is pending");
  a_one_read: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("Read taken while data is pending");
  a_bad_waddr: assert property (wr_hs && s_axi_awaddr == 8'h14 |-> ##2 s_axi_bresp == `WDMS_RESP_SLVERR)
    else $error("Unmapped write not refused");
endmodule
